// ### core/nv_spi_pkg.sv
// Constants and types shared by the serial nonvolatile memory slave
`default_nettype none
package nv_spi_pkg;
   // Operation codes, sent most significant bit first
   localparam logic [7:0] OPC_ARM_WRITE   = 8'h06;
   localparam logic [7:0] OPC_DISARM      = 8'h04;
   localparam logic [7:0] OPC_STATUS_RD   = 8'h05;
   localparam logic [7:0] OPC_STATUS_WR   = 8'h01;
   localparam logic [7:0] OPC_ARRAY_RD    = 8'h03;
   localparam logic [7:0] OPC_ARRAY_WR    = 8'h02;
   localparam logic [7:0] OPC_IDENTITY_RD = 8'h9F;
   localparam logic [7:0] OPC_FAST_RD     = 8'h0B;
   localparam logic [7:0] OPC_SLEEP       = 8'hB9;

   // Array geometry
   localparam int         ADDR_W          = 18;
   localparam int         ADDR_BITS_SENT  = 24;
   localparam logic [4:0] ADDR_LAST_BIT   = 5'h17;
   localparam logic [4:0] BYTE_LAST_BIT   = 5'h07;
   localparam logic [4:0] ID_LAST_BIT     = 5'h1F;

   // Protection status register field positions
   localparam int STAT_LOCK_EN  = 7;
   localparam int STAT_GUARD_HI = 3;
   localparam int STAT_GUARD_LO = 2;
   localparam int STAT_ARM      = 1;
   localparam int STAT_ZERO     = 0;

   // Values after reset of the stored status bits [7:2]
   localparam logic [5:0] STAT_NV_RESET   = 6'h00;

   // Block-guard encodings
   localparam logic [1:0] GUARD_NONE      = 2'h0;
   localparam logic [1:0] GUARD_QUARTER   = 2'h1;
   localparam logic [1:0] GUARD_HALF      = 2'h2;
   localparam logic [1:0] GUARD_ALL       = 2'h3;

   // Serial link phases
   typedef enum logic [2:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_DUMMY,
      PH_OUT,
      PH_IN,
      PH_IGNORE
   } phase_t;

   // What the current command moves
   typedef enum logic [1:0] {
      KIND_ARRAY,
      KIND_STATUS,
      KIND_IDENTITY
   } kind_t;
endpackage
`default_nettype wire

// ### core/nv_spi_slave.sv
// Serial slave front end of a 256K x 8 nonvolatile memory
//
// How it works
// - Chip select high: standby, output floated, inputs ignored
// - Pause pin low floats output, ignores clock
// - Sample input rising edge, drive output falling
// - Works with clock idling low or high
// - Bit 7 lock enable, written and read
// - Bits 6-4 stored unused; bit 0 reads zero
// - Bits 3-2 block guard, written and read
// - Bit 1 arm latch, status write cannot alter
// - Arm clears at reset, disarm, write end
// - Incomplete operation code is never executed
// - Decode arm, disarm and status read codes
// - Decode status write, array read, array write
// - Decode identity read, fast read, sleep
// - Writes refused while arm latch is clear
// - Status byte out, repeated while clocked
// - Status write keeps bits 7-2 only
// - Array read takes 24-bit address, upper ignored
// - Read auto-increments and wraps to zero
// - Array write stores each whole byte
// - Further bytes increment and wrap; deselect ends
// - Fast read adds eight dummy bits
// - Guard 00 none, 01 quarter, 10 half, 11 all
// - Status write blocked when lock set, pin low
// - Deselect in pause aborts; unrecognised keeps arm
// - Sleep at deselect, cancelled by clock edge
`default_nettype none
module nv_spi_slave #(
   parameter logic [31:0] IDENTITY_WORD = 32'h5A5A_0001  // Arbitrary identity value
) (
   // System clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   // Serial pins from the host
   input  wire logic                          spi_clk,
   input  wire logic                          cs_b,
   input  wire logic                          si,
   input  wire logic                          hold_b,
   input  wire logic                          guard_pin_b,
   // Serial output pin, three signals
   output logic                               so,
   output logic                               so_oe,
   input  wire logic                          so_in,
   // Array port, on the serial clock
   output logic [nv_spi_pkg::ADDR_W-1:0]      mem_addr,
   output logic [7:0]                         mem_wdata,
   output logic                               mem_we,
   input  wire logic [7:0]                    mem_rdata,
   // State seen by the system
   output logic [7:0]                         status_value,
   output logic                               sleep_active
);

   // ==========================================================
   // Serial clock domain
   // ==========================================================
   logic                             frame_rst_b;
   nv_spi_pkg::phase_t               phase;
   nv_spi_pkg::kind_t                kind;
   logic [4:0]                       bit_cnt;
   logic [7:0]                       shift_in;
   logic [7:0]                       opcode;
   logic [23:0]                      addr_shift;
   logic [nv_spi_pkg::ADDR_W-1:0]    addr;
   logic                             fast;
   logic                             writing_array;
   logic                             sleep_watch;
   logic [7:0]                       status_data;
   logic [8:0]                       lstat_meta;
   logic [8:0]                       lstat;
   logic                             out_bit;
   logic                             so_q;
   logic                             drive_q;
   logic                             guarded;
   // Event toggles handed to the system side
   logic                             arm_tgl;
   logic                             disarm_tgl;
   logic                             swr_tgl;
   logic                             end_tgl;
   logic                             sleep_tgl;
   logic                             cancel_tgl;

   // Deselect or reset clears every frame register
   assign frame_rst_b = rst_b & ~cs_b;

   assign opcode = {shift_in[6:0], si};

   // Status and sleep state carried over from the system side
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         lstat_meta <= 9'h000;
         lstat      <= 9'h000;
      end else begin
         lstat_meta <= {sleep_active, status_value};
         lstat      <= lstat_meta;
      end
   end

   // Address protected by the block-guard bits
   always_comb begin
      case (lstat[nv_spi_pkg::STAT_GUARD_HI:nv_spi_pkg::STAT_GUARD_LO])
         nv_spi_pkg::GUARD_NONE:    guarded = 1'b0;
         nv_spi_pkg::GUARD_QUARTER: guarded = (addr[17:16] == 2'h3);
         nv_spi_pkg::GUARD_HALF:    guarded = addr[17];
         nv_spi_pkg::GUARD_ALL:     guarded = 1'b1;
         default:                   guarded = 1'b1;
      endcase
   end

   // Array write strobe, taken by the memory on this rising edge
   assign mem_addr  = addr;
   assign mem_wdata = opcode;
   assign mem_we    = ~cs_b & hold_b & ~lstat[8] & (phase == nv_spi_pkg::PH_IN)
                      & writing_array & (bit_cnt == nv_spi_pkg::BYTE_LAST_BIT)
                      & lstat[nv_spi_pkg::STAT_ARM] & ~guarded;

   // Command sequencer, samples input on rising edges
   always_ff @(posedge spi_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         phase         <= nv_spi_pkg::PH_OPCODE;
         kind          <= nv_spi_pkg::KIND_ARRAY;
         bit_cnt       <= 5'h00;
         shift_in      <= 8'h00;
         addr_shift    <= 24'h000000;
         addr          <= '0;
         fast          <= 1'b0;
         writing_array <= 1'b0;
         sleep_watch   <= 1'b0;
      end else if (hold_b && !lstat[8]) begin
         shift_in <= opcode;
         case (phase)
            nv_spi_pkg::PH_OPCODE: begin
               bit_cnt <= bit_cnt + 5'h01;
               if (bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
                  bit_cnt <= 5'h00;
                  phase   <= nv_spi_pkg::PH_IGNORE;
                  case (opcode)
                     nv_spi_pkg::OPC_STATUS_RD: begin
                        phase <= nv_spi_pkg::PH_OUT;
                        kind  <= nv_spi_pkg::KIND_STATUS;
                     end
                     nv_spi_pkg::OPC_STATUS_WR: begin
                        phase <= nv_spi_pkg::PH_IN;
                        kind  <= nv_spi_pkg::KIND_STATUS;
                     end
                     nv_spi_pkg::OPC_ARRAY_RD: begin
                        phase <= nv_spi_pkg::PH_ADDR;
                     end
                     nv_spi_pkg::OPC_ARRAY_WR: begin
                        phase         <= nv_spi_pkg::PH_ADDR;
                        writing_array <= 1'b1;
                     end
                     nv_spi_pkg::OPC_FAST_RD: begin
                        phase <= nv_spi_pkg::PH_ADDR;
                        fast  <= 1'b1;
                     end
                     nv_spi_pkg::OPC_IDENTITY_RD: begin
                        phase <= nv_spi_pkg::PH_OUT;
                        kind  <= nv_spi_pkg::KIND_IDENTITY;
                     end
                     nv_spi_pkg::OPC_SLEEP: begin
                        sleep_watch <= 1'b1;
                     end
                     default: begin
                        phase <= nv_spi_pkg::PH_IGNORE;
                     end
                  endcase
               end
            end
            nv_spi_pkg::PH_ADDR: begin
               addr_shift <= {addr_shift[22:0], si};
               bit_cnt    <= bit_cnt + 5'h01;
               if (bit_cnt == nv_spi_pkg::ADDR_LAST_BIT) begin
                  bit_cnt <= 5'h00;
                  addr    <= {addr_shift[nv_spi_pkg::ADDR_W-2:0], si};
                  if (writing_array) begin
                     phase <= nv_spi_pkg::PH_IN;
                  end else if (fast) begin
                     phase <= nv_spi_pkg::PH_DUMMY;
                  end else begin
                     phase <= nv_spi_pkg::PH_OUT;
                  end
               end
            end
            nv_spi_pkg::PH_DUMMY: begin
               bit_cnt <= bit_cnt + 5'h01;
               if (bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
                  bit_cnt <= 5'h00;
                  phase   <= nv_spi_pkg::PH_OUT;
               end
            end
            nv_spi_pkg::PH_OUT: begin
               if (kind == nv_spi_pkg::KIND_IDENTITY) begin
                  if (bit_cnt != nv_spi_pkg::ID_LAST_BIT) begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end else if (bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
                  bit_cnt <= 5'h00;
                  if (kind == nv_spi_pkg::KIND_ARRAY) begin
                     addr <= addr + 1'b1;
                  end
               end else begin
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            nv_spi_pkg::PH_IN: begin
               if (bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
                  bit_cnt <= 5'h00;
                  if (writing_array) begin
                     addr <= addr + 1'b1;
                  end else begin
                     phase <= nv_spi_pkg::PH_IGNORE;
                  end
               end else begin
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            nv_spi_pkg::PH_IGNORE: begin
               sleep_watch <= 1'b0;
            end
            default: begin
               phase <= nv_spi_pkg::PH_IGNORE;
            end
         endcase
      end
   end

   // Status write data, held until the next status write
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_data <= 8'h00;
      end else if (!cs_b && hold_b && !lstat[8] && phase == nv_spi_pkg::PH_IN
                   && !writing_array && bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
         status_data <= opcode;
      end
   end

   // Events for the system side, one toggle per event
   always_ff @(posedge spi_clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_tgl    <= 1'b0;
         disarm_tgl <= 1'b0;
         swr_tgl    <= 1'b0;
         end_tgl    <= 1'b0;
         sleep_tgl  <= 1'b0;
         cancel_tgl <= 1'b0;
      end else if (!cs_b && hold_b && !lstat[8]) begin
         if (phase == nv_spi_pkg::PH_OPCODE && bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
            if (opcode == nv_spi_pkg::OPC_ARM_WRITE) begin
               arm_tgl <= ~arm_tgl;
            end
            if (opcode == nv_spi_pkg::OPC_DISARM) begin
               disarm_tgl <= ~disarm_tgl;
            end
            if (opcode == nv_spi_pkg::OPC_STATUS_WR || opcode == nv_spi_pkg::OPC_ARRAY_WR) begin
               end_tgl <= ~end_tgl;
            end
            if (opcode == nv_spi_pkg::OPC_SLEEP) begin
               sleep_tgl <= ~sleep_tgl;
            end
         end
         if (phase == nv_spi_pkg::PH_IN && !writing_array
             && bit_cnt == nv_spi_pkg::BYTE_LAST_BIT) begin
            swr_tgl <= ~swr_tgl;
         end
         if (phase == nv_spi_pkg::PH_IGNORE && sleep_watch) begin
            cancel_tgl <= ~cancel_tgl;
         end
      end
   end

   // Next output bit, most significant first
   always_comb begin
      case (kind)
         nv_spi_pkg::KIND_STATUS:   out_bit = lstat[3'h7 - bit_cnt[2:0]];
         nv_spi_pkg::KIND_IDENTITY: out_bit = IDENTITY_WORD[5'h1F - bit_cnt];
         default:                   out_bit = mem_rdata[3'h7 - bit_cnt[2:0]];
      endcase
   end

   // Output changes on falling edges
   always_ff @(negedge spi_clk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         so_q    <= 1'b0;
         drive_q <= 1'b0;
      end else if (hold_b) begin
         so_q    <= out_bit;
         drive_q <= (phase == nv_spi_pkg::PH_OUT) & ~lstat[8];
      end
   end

   // Output pin floats in standby, pause and non-read phases
   assign so    = so_q;
   assign so_oe = drive_q & hold_b & ~cs_b;

   // ==========================================================
   // System clock domain
   // ==========================================================
   logic [7:0]   sync_meta;
   logic [7:0]   sync_q;
   logic [7:0]   sync_prev;
   logic [7:0]   evt;
   logic         cs_rise;
   logic         cs_fall;
   logic         guard_s;
   logic [5:0]   nv_bits;
   logic         arm_flag;
   logic         end_pend;
   logic         sleep_pend;
   logic         swr_allowed;

   // Two-flop synchronisers for toggles and pins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync_meta <= 8'hC0;
         sync_q    <= 8'hC0;
         sync_prev <= 8'hC0;
      end else begin
         sync_meta <= {cs_b, guard_pin_b, cancel_tgl, sleep_tgl,
                       end_tgl, swr_tgl, disarm_tgl, arm_tgl};
         sync_q    <= sync_meta;
         sync_prev <= sync_q;
      end
   end

   assign evt     = sync_q ^ sync_prev;
   assign cs_rise = evt[7] & sync_q[7];
   assign cs_fall = evt[7] & ~sync_q[7];
   assign guard_s = sync_q[6];

   // Status write refused unless armed and not locked by the pin
   assign swr_allowed = arm_flag & ~(nv_bits[5] & ~guard_s);

   // Stored status bits 7 to 2
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nv_bits <= nv_spi_pkg::STAT_NV_RESET;
      end else if (evt[2] && swr_allowed) begin
         nv_bits <= status_data[7:2];
      end
   end

   // Write-arm latch; recognised write marks the deselect clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arm_flag <= 1'b0;
         end_pend <= 1'b0;
      end else begin
         if (evt[0]) begin
            arm_flag <= 1'b1;
         end else if (evt[1] || (cs_rise && end_pend)) begin
            arm_flag <= 1'b0;
         end
         if (evt[3]) begin
            end_pend <= 1'b1;
         end else if (cs_rise) begin
            end_pend <= 1'b0;
         end
      end
   end

   // Sleep entry at deselect, wake on the next select
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sleep_pend   <= 1'b0;
         sleep_active <= 1'b0;
      end else begin
         if (evt[4]) begin
            sleep_pend <= 1'b1;
         end else if (evt[5] || cs_rise) begin
            sleep_pend <= 1'b0;
         end
         if (cs_rise && sleep_pend && !evt[5]) begin
            sleep_active <= 1'b1;
         end else if (cs_fall) begin
            sleep_active <= 1'b0;
         end
      end
   end

   // Status image; bit 0 is always zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         status_value <= 8'h00;
      end else begin
         status_value <= {nv_bits, arm_flag, 1'b0};
      end
   end

endmodule
`default_nettype wire

// ### tb/nv_spi_slave_assertions.sv
// Concurrent checks on the ports of the serial memory slave
`default_nettype none
module nv_spi_slave_assertions (
   // System clock and reset
   input wire logic                          clk_sys,
   input wire logic                          rst_b,
   // Serial pins
   input wire logic                          spi_clk,
   input wire logic                          cs_b,
   input wire logic                          hold_b,
   input wire logic                          so_oe,
   // Array port and visible state
   input wire logic [nv_spi_pkg::ADDR_W-1:0] mem_addr,
   input wire logic                          mem_we,
   input wire logic [7:0]                    status_value,
   input wire logic                          sleep_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================
   // Output pin ownership
   a_standby_floats: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cs_b |-> !so_oe) else $error("output driven while deselected");
   a_pause_floats: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !hold_b |-> !so_oe) else $error("output driven during pause");
   a_sleep_floats: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sleep_active |-> !so_oe) else $error("output driven while asleep");
   // ==================================================
   // Array write permission
   a_write_needs_arm: assert property (@(posedge spi_clk) disable iff (!rst_b)
      mem_we |-> status_value[nv_spi_pkg::STAT_ARM]) else $error("array write while disarmed");
   a_guard_blocks: assert property (@(posedge spi_clk) disable iff (!rst_b)
      mem_we |-> !((status_value[3:2] == nv_spi_pkg::GUARD_ALL)
      || (status_value[3:2] == nv_spi_pkg::GUARD_HALF && mem_addr[17])
      || (status_value[3:2] == nv_spi_pkg::GUARD_QUARTER && mem_addr[17:16] == 2'h3)))
      else $error("write into guarded block");
   a_sleep_no_write: assert property (@(posedge spi_clk) disable iff (!rst_b)
      sleep_active |-> !mem_we) else $error("array write while asleep");
   a_write_floats: assert property (@(posedge spi_clk) disable iff (!rst_b)
      mem_we |-> !so_oe) else $error("output driven while taking write data");
   // ==================================================
   // Status image
   a_zero_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(status_value) |-> status_value[nv_spi_pkg::STAT_ZERO] == 1'b0)
      else $error("status bit 0 not zero");
   a_reset_status: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> status_value == {nv_spi_pkg::STAT_NV_RESET, 2'h0})
      else $error("status not clear after reset");
endmodule

bind nv_spi_slave nv_spi_slave_assertions chk (
   .clk_sys (clk_sys), .rst_b (rst_b), .spi_clk (spi_clk), .cs_b (cs_b), .hold_b (hold_b),
   .so_oe (so_oe), .mem_addr (mem_addr), .mem_we (mem_we), .status_value (status_value),
   .sleep_active (sleep_active));
`default_nettype wire

// ### tb/nv_spi_host.sv
// Host controller model that clocks frames, whole or cut short, into the slave
`default_nettype none
module nv_spi_host (
   // Serial pins toward the slave
   output logic     spi_clk,
   output logic     cs_b,
   output logic     si,
   output logic     hold_b,
   // Pin level read back
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cpol = 1'b0;   // Idle clock level, mode 0 or mode 3
   int   cut_at = -1;   // Bit count at which the frame is cut short
   int   pause_at = -1; // Bit count before which a pause is inserted

   // ==================================================
   // Idle pins
   initial begin
      spi_clk = 1'b0;
      cs_b = 1'b1;
      si = 1'b0;
      hold_b = 1'b1;
   end

   // One frame, 32 ns clock running only while selected
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      int         n;
      n = 0;
      rx = {};
      spi_clk = cpol;
      #10 cs_b = 1'b0;
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            if (cut_at < 0 || n < cut_at) begin
               if (n == pause_at) begin
                  hold_b = 1'b0;
                  si = ~si;
                  #16 spi_clk = ~spi_clk;
                  #16 spi_clk = ~spi_clk;
                  #16 hold_b = 1'b1;
                  #16;
               end
               if (cpol) spi_clk = 1'b0;
               si = tx[i][k];
               #16 spi_clk = 1'b1;
               b = {b[6:0], so};
               #16 if (!cpol) spi_clk = 1'b0;
               n++;
               if (k == 0) rx.push_back(b);
            end
         end
      end
      #40 cs_b = 1'b1;
      si = ~si;
      #100;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_spi_serial_nv_memory_slave.sv
// Self-checking bench for the serial memory slave
`default_nettype none
module tb_spi_serial_nv_memory_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ID_VAL = 32'hC3A5_1E0F; // Arbitrary identity value
   // ==================================================
   // Signals
   logic        clk_sys = 1'b0;
   logic        rst_b, guard_pin_b, spi_clk, cs_b, si, hold_b, so, so_oe, so_in;
   logic [17:0] mem_addr;
   logic [7:0]  mem_wdata, mem_rdata, status_value, st_exp;
   logic        mem_we, sleep_active;
   logic [7:0]  mem [0:262143];
   logic [7:0]  ref_mem [int];
   logic [7:0]  q[$], r[$];
   logic [31:0] seed = 32'h0000_813B;
   int          errors = 0;
   int          samples_checked = 0;

   always #10 clk_sys = ~clk_sys;
   // Pin level seen back: inverted last value when floated
   assign so_in = so_oe ? so : ~so;
   // Array behind the slave, read without a clock
   assign mem_rdata = mem[mem_addr];
   always @(posedge spi_clk) if (mem_we) mem[mem_addr] <= mem_wdata;

   nv_spi_host host (.spi_clk (spi_clk), .cs_b (cs_b), .si (si), .hold_b (hold_b), .so (so_in));
   nv_spi_slave #(.IDENTITY_WORD (ID_VAL)) dut (
      .clk_sys (clk_sys), .rst_b (rst_b), .spi_clk (spi_clk), .cs_b (cs_b), .si (si),
      .hold_b (hold_b), .guard_pin_b (guard_pin_b), .so (so), .so_oe (so_oe), .so_in (so_in),
      .mem_addr (mem_addr), .mem_wdata (mem_wdata), .mem_we (mem_we), .mem_rdata (mem_rdata),
      .status_value (status_value), .sleep_active (sleep_active));

   // ==================================================
   // Expectation helpers
   function automatic logic [7:0] pat(input logic [17:0] a);
      return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
   endfunction
   function automatic logic [7:0] exp_byte(input logic [17:0] a);
      return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : pat(a);
   endfunction
   function automatic logic blocked(input logic [1:0] g, input logic [17:0] a);
      return g == 2'h3 || (g == 2'h2 && a[17]) || (g == 2'h1 && a[17:16] == 2'h3);
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0440_0007 : 32'h0000_0000);
   endfunction
   task automatic rnd(output logic [7:0] v);
      seed = lfsr(seed);
      v = seed[7:0];
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==================================================
   // Command tasks
   task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int n);
      logic [7:0] v;
      q = {op, a[23:16], a[15:8], a[7:0]};
      rnd(v);
      if (op == nv_spi_pkg::OPC_FAST_RD) q.push_back(v);
      repeat (n) begin
         rnd(v);
         q.push_back(v);
      end
      host.frame(q, r);
   endtask
   task automatic arm();
      q = {nv_spi_pkg::OPC_ARM_WRITE};
      host.frame(q, r);
      st_exp[1] = 1'b1;
   endtask
   task automatic st_wr(input logic [7:0] v);
      arm();
      q = {nv_spi_pkg::OPC_STATUS_WR, v};
      host.frame(q, r);
      if (!(st_exp[7] && !guard_pin_b)) st_exp[7:2] = v[7:2];
      st_exp[1] = 1'b0;
   endtask
   task automatic st_rd();
      q = {nv_spi_pkg::OPC_STATUS_RD, 8'h00, 8'hFF};
      host.frame(q, r);
      check(r[1], st_exp);
      check(r[2], st_exp);
      check(status_value, st_exp);
   endtask
   task automatic wr(input logic [23:0] a, input int n);
      logic [17:0] ad;
      xfer(nv_spi_pkg::OPC_ARRAY_WR, a, n);
      for (int i = 0; i < n; i++) begin
         ad = a[17:0] + 18'(i);
         if (st_exp[1] && !blocked(st_exp[3:2], ad)) ref_mem[int'(ad)] = q[4 + i];
      end
      st_exp[1] = 1'b0;
   endtask
   task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
      int off;
      off = (op == nv_spi_pkg::OPC_FAST_RD) ? 5 : 4;
      xfer(op, a, n);
      for (int i = 0; i < n; i++) check(r[off + i], exp_byte(a[17:0] + 18'(i)));
   endtask
   task automatic pin(input logic v);
      @(posedge clk_sys);
      #2 guard_pin_b = v;
   endtask

   // ==================================================
   // Watchdog
   initial begin
      #400_000; // About four times the length of all tests
      errors++;
      conclude();
   end

   // ==================================================
   // Main sequence
   initial begin
      logic [7:0] v;
      rst_b = 1'b0;
      guard_pin_b = 1'b1;
      st_exp = 8'h00;
      for (int i = 0; i < 262144; i++) mem[i] = pat(18'(i));
      repeat (8) @(posedge clk_sys);
      #2 rst_b = 1'b1;
      repeat (3) @(posedge clk_sys);
      st_rd();
      host.cut_at = 5;
      arm();
      host.cut_at = -1;
      st_exp[1] = 1'b0;
      st_rd();
      wr(24'hFC1234, 2);
      rd(nv_spi_pkg::OPC_ARRAY_RD, 24'h3C1234, 2);
      arm();
      st_rd();
      q = {nv_spi_pkg::OPC_DISARM};
      host.frame(q, r);
      st_exp[1] = 1'b0;
      st_rd();
      q = {nv_spi_pkg::OPC_STATUS_WR, 8'hFC};
      host.frame(q, r);
      st_rd();
      done("arm");
      st_wr(8'hFF);
      st_rd();
      pin(1'b0);
      st_wr(8'h00);
      st_rd();
      pin(1'b1);
      for (int g = 0; g < 4; g++) begin
         rnd(v);
         st_wr({1'b0, v[6:4], g[1:0], 2'b00});
         st_rd();
         for (int k = 0; k < 4; k++) begin
            arm();
            rnd(v);
            wr({v[5:0], k[1:0], v, ~v}, 2);
            rd(nv_spi_pkg::OPC_ARRAY_RD, {~v[5:0], k[1:0], v, ~v}, 2);
         end
      end
      done("guard");
      st_wr(8'h00);
      arm();
      wr(24'h03FFFE, 4);
      st_rd();
      host.cpol = 1'b1;
      rd(nv_spi_pkg::OPC_ARRAY_RD, 24'hFFFFFF, 3);
      rd(nv_spi_pkg::OPC_FAST_RD, 24'h03FFFD, 5);
      host.cpol = 1'b0;
      host.pause_at = 41;
      rd(nv_spi_pkg::OPC_ARRAY_RD, 24'h03FFFE, 3);
      host.pause_at = -1;
      done("stream");
      q = {nv_spi_pkg::OPC_IDENTITY_RD, 8'h00, 8'h00, 8'h00, 8'h00};
      host.frame(q, r);
      check({r[1], r[2], r[3], r[4]}, ID_VAL);
      q = {nv_spi_pkg::OPC_SLEEP, 8'h00};
      host.frame(q, r);
      check(sleep_active, 1'b0);
      q = {nv_spi_pkg::OPC_SLEEP};
      host.frame(q, r);
      check(sleep_active, 1'b1);
      host.cut_at = 0;
      host.frame(q, r);
      host.cut_at = -1;
      check(sleep_active, 1'b0);
      q = {nv_spi_pkg::OPC_DISARM};
      host.frame(q, r);
      st_rd();
      done("sleep");
      conclude();
   end
endmodule
`default_nettype wire
